// ===== shared/npic_map.svh
// offsets, field layouts, reset values and codes of the interrupt controller
//
// Operation
// RULE1: on acceptance, finish the instruction, then stack PC, X, A and CC.
// RULE2: on entry, load the current level with the vector's stored level.
// RULE3: after stacking, load the vector address and start fetching there.
// RULE4: return from handler pops the level bits, resuming the old level.
// RULE5: four nesting levels, two non-maskable events, one top-level event.
// RULE6: level codes: 0 is 10, 1 is 01, 2 is 00, 3 is 11.
// RULE7: pick highest software level first, then highest hardware order.
// RULE8: an unserviced request stays latched until it becomes the winner.
// RULE9: top-level pin, reset and trap count as highest software level.
// RULE10: reset and trap ignore level, set level 3, wake from halt.
// RULE11: trap instruction raises the trap; top-level pin may preempt it.
// RULE12: reset wins everything; its routine runs at level 3.
// RULE13: maskable request served only if enabled and above current level.
// RULE14: top-level pin edge raises a trap-like request; no trap inside.
// RULE15: edge external requests latch and clear on handler entry.
// RULE16: selected pins sharing one external line are ORed together.
// RULE17: peripheral request is its status flag and its enable together.
// RULE18: peripheral clear sequence also drops the latched request.
// RULE19: any request wakes from wait; only halt-capable ones from halt.
// RULE20: after halt, first served is the winning halt-capable source.
// RULE21: hardware order rises vector 13 up to vector 0, then top-level.
// RULE22: vectors sit at fixed addresses from ffe0 to ffff.
// RULE23: writing level 0 into a priority field leaves the field unchanged.
// RULE24: enable loads level code 10, disable loads level code 11.
// RULE25: four priority registers, two bits per vector, reset to ff.
`ifndef NPIC_MAP_SVH
`define NPIC_MAP_SVH

// ------------------------------------------------------------
// register offsets (3-bit word index)
// ------------------------------------------------------------
`define NPIC_OFS_PRIO0 3'h0
`define NPIC_OFS_PRIO3 3'h3
`define NPIC_OFS_STAT 3'h4
`define NPIC_OFS_CTRL 3'h5
`define NPIC_OFS_PENDL 3'h6
`define NPIC_OFS_PENDH 3'h7

// ------------------------------------------------------------
// reset values, level codes, vector map
// ------------------------------------------------------------
`define NPIC_PRIO_RST 8'hff
`define NPIC_PRIO3_RO 8'hf0
`define NPIC_CTRL_RST 2'h3
`define NPIC_CTRL_TLI_EN 0
`define NPIC_CTRL_TLI_RISE 1
`define NPIC_LVL0 2'h2
`define NPIC_LVL1 2'h1
`define NPIC_LVL2 2'h0
`define NPIC_LVL3 2'h3
`define NPIC_VEC_RESET 16'hfffe
`define NPIC_VEC_TRAP 16'hfffc
`define NPIC_VEC_BASE 16'hfffa
`define NPIC_HALT_CAP 14'h00ff
`define NPIC_TLI_RANK 3'h4

`endif

// ===== shared/npic_pkg.sv
// types and helpers shared by the interrupt controller files
package npic_pkg;

	typedef enum logic [1:0] {SLP_AWAKE, SLP_WAIT, SLP_HALT} npic_sleep_t;
	typedef enum logic [1:0] {ST_RUN, ST_STACK, ST_VECTOR} npic_state_t;
	typedef enum logic [1:0] {SRC_RESET, SRC_TRAP, SRC_VEC} npic_src_t;

	// level code to rank: 10->0, 01->1, 00->2, 11->3
	function automatic logic [1:0] npic_rank(input logic [1:0] code);
		return {~(code[1] ^ code[0]), code[0]};
	endfunction

	// merge a write into a priority byte, keeping fields written as 10
	function automatic logic [7:0] npic_merge(input logic [7:0] old_v,
		input logic [7:0] new_v);
		logic [7:0] res;
		res = old_v;
		for (int f = 0; f < 4; f++) begin
			if (new_v[2*f +: 2] != 2'h2) begin
				res[2*f +: 2] = new_v[2*f +: 2];
			end
		end
		return res;
	endfunction

endpackage

// ===== src/npic_ctrl.sv
// nested priority interrupt controller: latching, arbitration, entry
`timescale 1ns/1ps
`include "npic_map.svh"

module npic_ctrl (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic top_level_pin_irq,
	input wire logic [15:0] ext_pin_in,
	input wire logic [15:0] ext_pin_sel,
	input wire logic [13:0] periph_flag,
	input wire logic [13:0] periph_en,
	input wire logic [13:0] periph_clr,
	input wire logic instr_done,
	input wire logic trap_instr,
	input wire logic return_from_handler,
	input wire logic [1:0] popped_level,
	input wire logic enable_irqs_instr,
	input wire logic disable_irqs_instr,
	input wire logic halt_instr,
	input wire logic wait_instr,
	input wire logic ctx_push_done,
	output logic ctx_push_req,
	output logic fetch_req,
	output logic [15:0] fetch_addr,
	output logic level_high_bit,
	output logic level_low_bit,
	output npic_pkg::npic_sleep_t sleep_mode
);
	import npic_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] prio0;
	logic [7:0] prio1;
	logic [7:0] prio2;
	logic [7:0] prio3;
	logic [1:0] ctrl_reg;
	logic [13:0] pend;
	logic trap_pend;
	logic reset_pend;
	logic in_tli;
	logic halt_first;
	logic tli_prev;
	logic [3:0] ext_prev;
	logic [3:0] win_idx_q;
	npic_state_t state;
	npic_src_t src_q;

	// ------------------------------------------------------------
	// combinational nets
	// ------------------------------------------------------------
	logic [1:0] cur_level;
	logic [1:0] cur_rank;
	logic [31:0] prio_flat;
	logic [13:0] req_set;
	logic [13:0] req_clr;
	logic [13:0] cand_ok;
	logic [13:0] next_pend;
	logic [3:0] ext_line;
	logic tli_edge;
	logic [2:0] eff_rank [0:13];
	logic best_valid [0:14];
	logic [2:0] best_rank [0:14];
	logic [3:0] best_idx [0:14];
	logic any_service;
	logic take;
	logic vec_stage;
	logic entry_vec;
	logic [1:0] entry_level;
	logic [1:0] next_level;
	logic [15:0] next_fetch_addr;
	logic [7:0] rd_mux;
	logic [7:0] stat_val;
	npic_src_t next_src;

	assign cur_level = {level_high_bit, level_low_bit};
	assign cur_rank = npic_rank(cur_level); // RULE6
	assign prio_flat = {prio3, prio2, prio1, prio0};

	// sources allowed to end a halt; the rest wait for the first entry
	localparam logic [13:0] halt_cap = `NPIC_HALT_CAP;

	// ------------------------------------------------------------
	// request sources
	// ------------------------------------------------------------

	// top-level pin edge, polarity chosen in the control register
	assign tli_edge = ctrl_reg[`NPIC_CTRL_TLI_RISE] ?
		(top_level_pin_irq & ~tli_prev) :
		(~top_level_pin_irq & tli_prev); // RULE14

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ext
			// selected pins of one group share the line
			assign ext_line[g] =
				|(ext_pin_in[4*g +: 4] & ext_pin_sel[4*g +: 4]); // RULE16
		end
	endgenerate

	// per-vector latching, eligibility and ranking
	genvar i;
	generate
		for (i = 0; i < 14; i++) begin : g_vec
			logic [1:0] code;
			logic above;
			logic wake_ok;
			assign code = prio_flat[2*i +: 2];
			// one mask bit per position, so no wide compare can leak through
			assign wake_ok = ~halt_first | halt_cap[i]; // RULE19 RULE20
			if (i == 0) begin : g_tli
				assign req_set[i] = tli_edge; // RULE14
				assign req_clr[i] = entry_vec & (win_idx_q == 4'(i));
				assign above = ctrl_reg[`NPIC_CTRL_TLI_EN] & ~in_tli; // RULE11
				assign eff_rank[i] = `NPIC_TLI_RANK; // RULE9
			end else if (i >= 2 && i <= 5) begin : g_ext_vec
				// edge on the ORed line latches; entry clears it
				assign req_set[i] = ext_line[i-2] & ~ext_prev[i-2]; // RULE15
				assign req_clr[i] = entry_vec & (win_idx_q == 4'(i)); // RULE15
				assign above = npic_rank(code) > cur_rank; // RULE13
				assign eff_rank[i] = {1'b0, npic_rank(code)};
			end else begin : g_periph
				// flag with enable; clear sequence discards the latch
				assign req_set[i] = periph_flag[i] & periph_en[i]; // RULE17
				assign req_clr[i] = periph_clr[i] |
					(entry_vec & (win_idx_q == 4'(i))); // RULE18
				assign above = npic_rank(code) > cur_rank; // RULE13
				assign eff_rank[i] = {1'b0, npic_rank(code)};
			end
			// after halt only halt-capable sources may be first
			assign cand_ok[i] = pend[i] & above &
				wake_ok; // RULE20
			// a new request in the clearing cycle is kept
			assign next_pend[i] = req_set[i] | (pend[i] & ~req_clr[i]); // RULE8
		end
	endgenerate

	// ------------------------------------------------------------
	// arbitration chain: rank first, lower index wins ties
	// ------------------------------------------------------------
	assign best_valid[0] = 1'b0;
	assign best_rank[0] = 3'h0;
	assign best_idx[0] = 4'h0;

	generate
		for (i = 0; i < 14; i++) begin : g_arb
			logic beats;
			// strict compare keeps the earlier, higher hardware order
			assign beats = cand_ok[i] &
				(~best_valid[i] | (eff_rank[i] > best_rank[i])); // RULE7 RULE21
			assign best_valid[i+1] = best_valid[i] | cand_ok[i];
			assign best_rank[i+1] = beats ? eff_rank[i] : best_rank[i];
			assign best_idx[i+1] = beats ? 4'(i) : best_idx[i];
		end
	endgenerate

	// ------------------------------------------------------------
	// service decision
	// ------------------------------------------------------------

	// reset outranks trap, trap outranks every vector, level ignored
	assign any_service = reset_pend | trap_pend | best_valid[14]; // RULE10
	// only between instructions, or while the core sleeps
	assign take = (state == ST_RUN) & any_service &
		(instr_done | (sleep_mode != SLP_AWAKE)); // RULE1 RULE19
	// the two non-maskable sources sit ahead of every vector
	assign next_src = reset_pend ? SRC_RESET : // RULE5
		(trap_pend ? SRC_TRAP : SRC_VEC); // RULE12
	// entry stage: level, address and latch clears all act here
	assign vec_stage = (state == ST_VECTOR);
	assign entry_vec = vec_stage & (src_q == SRC_VEC);

	// level and address loaded on entry
	assign entry_level = (src_q != SRC_VEC || win_idx_q == 4'h0) ?
		`NPIC_LVL3 : prio_flat[{win_idx_q, 1'b0} +: 2]; // RULE2 RULE10
	assign next_fetch_addr = (src_q == SRC_RESET) ? `NPIC_VEC_RESET :
		(src_q == SRC_TRAP) ? `NPIC_VEC_TRAP :
		`NPIC_VEC_BASE - {11'h000, win_idx_q, 1'b0}; // RULE22

	// entry beats instructions; return restores the popped level
	assign next_level = vec_stage ? entry_level :
		return_from_handler ? popped_level : // RULE4
		(enable_irqs_instr | halt_instr | wait_instr) ? `NPIC_LVL0 :
		disable_irqs_instr ? `NPIC_LVL3 : cur_level; // RULE24

	// ------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------
	assign stat_val = {2'h0, reset_pend, trap_pend, in_tli, halt_first,
		level_high_bit, level_low_bit};
	assign rd_mux = (reg_addr == 3'h0) ? prio0 :
		(reg_addr == 3'h1) ? prio1 :
		(reg_addr == 3'h2) ? prio2 :
		(reg_addr == `NPIC_OFS_PRIO3) ? prio3 :
		(reg_addr == `NPIC_OFS_STAT) ? stat_val :
		(reg_addr == `NPIC_OFS_CTRL) ? {6'h00, ctrl_reg} :
		(reg_addr == `NPIC_OFS_PENDL) ? pend[7:0] :
		{2'h0, pend[13:8]};

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------

	// priority writes skip fields written as level 0
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			prio0 <= `NPIC_PRIO_RST; // RULE25
			prio1 <= `NPIC_PRIO_RST;
			prio2 <= `NPIC_PRIO_RST;
			prio3 <= `NPIC_PRIO_RST;
			ctrl_reg <= `NPIC_CTRL_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				3'h0: prio0 <= npic_merge(prio0, reg_wdata); // RULE23
				3'h1: prio1 <= npic_merge(prio1, reg_wdata); // RULE23
				3'h2: prio2 <= npic_merge(prio2, reg_wdata); // RULE23
				`NPIC_OFS_PRIO3:
					prio3 <= npic_merge(prio3, reg_wdata) |
						`NPIC_PRIO3_RO; // RULE23
				`NPIC_OFS_CTRL: ctrl_reg <= reg_wdata[1:0];
				default: ;
			endcase
		end
	end

	// read data stands in the cycle after the strobe only
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// pending latches and edge history
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pend <= 14'h0000;
			tli_prev <= 1'b0;
			ext_prev <= 4'h0;
		end else begin
			pend <= next_pend; // RULE8
			tli_prev <= top_level_pin_irq;
			ext_prev <= ext_line;
		end
	end

	// trap is held until its entry; set wins over the clear
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			trap_pend <= 1'b0;
		end else begin
			trap_pend <= trap_instr |
				(trap_pend & ~(vec_stage & (src_q == SRC_TRAP))); // RULE11
		end
	end

	// reset vector is fetched first, without stacking
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			reset_pend <= 1'b1; // RULE12
		end else if (vec_stage && src_q == SRC_RESET) begin
			reset_pend <= 1'b0;
		end
	end

	// top-level handler cannot be re-entered until the next return from any handler
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			in_tli <= 1'b0;
		end else if (entry_vec && win_idx_q == 4'h0) begin
			in_tli <= 1'b1;
		end else if (return_from_handler) begin
			in_tli <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// current level bits
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			level_high_bit <= 1'b1; // RULE12
			level_low_bit <= 1'b1;
		end else begin
			level_high_bit <= next_level[1]; // RULE2 RULE4
			level_low_bit <= next_level[0];
		end
	end

	// ------------------------------------------------------------
	// low power tracking
	// ------------------------------------------------------------

	// halt masks non-capable sources until the first entry is done
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sleep_mode <= SLP_AWAKE;
			halt_first <= 1'b0;
		end else begin
			if (take) begin
				sleep_mode <= SLP_AWAKE; // RULE19
			end else if (halt_instr) begin
				sleep_mode <= SLP_HALT;
			end else if (wait_instr) begin
				sleep_mode <= SLP_WAIT;
			end
			if (halt_instr) begin
				halt_first <= 1'b1;
			end else if (vec_stage) begin
				halt_first <= 1'b0; // RULE20
			end
		end
	end

	// ------------------------------------------------------------
	// entry sequencer
	// ------------------------------------------------------------

	// winner is frozen at take so a late request cannot swap vectors
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state <= ST_RUN;
			src_q <= SRC_RESET;
			win_idx_q <= 4'h0;
			ctx_push_req <= 1'b0;
			fetch_req <= 1'b0;
			fetch_addr <= 16'h0000;
		end else begin
			fetch_req <= 1'b0;
			case (state)
				ST_RUN: begin
					if (take) begin
						src_q <= next_src;
						win_idx_q <= best_idx[14]; // RULE7
						if (next_src == SRC_RESET) begin
							state <= ST_VECTOR; // RULE10
						end else begin
							ctx_push_req <= 1'b1; // RULE1
							state <= ST_STACK;
						end
					end
				end
				ST_STACK: begin
					if (ctx_push_done) begin
						ctx_push_req <= 1'b0;
						state <= ST_VECTOR;
					end
				end
				ST_VECTOR: begin
					fetch_req <= 1'b1; // RULE3
					fetch_addr <= next_fetch_addr; // RULE3
					state <= ST_RUN;
				end
				default: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

endmodule

// ===== dv/npic_ctrl_assertions.sv
// port-level assertion checker for the interrupt controller
`timescale 1ns/1ps
module npic_ctrl_chk (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic ctx_push_req,
	input wire logic ctx_push_done,
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	input wire logic level_high_bit,
	input wire logic level_low_bit,
	input wire logic enable_irqs_instr,
	input wire logic disable_irqs_instr,
	input wire logic halt_instr,
	input wire logic wait_instr,
	input wire logic return_from_handler,
	input wire logic [1:0] popped_level,
	input wire npic_pkg::npic_sleep_t sleep_mode
);
	import npic_pkg::*;
	logic [1:0] lvl;
	// current level code as one field
	assign lvl = {level_high_bit, level_low_bit};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// ---------------------------------------------
	// entry steps: stacking acknowledged, then fetch
	// ---------------------------------------------
	sequence s_stacked;
		ctx_push_req && ctx_push_done;
	endsequence
	sequence s_fetch;
		##2 fetch_req;
	endsequence
	chk_push_fetch: assert property (s_stacked |-> s_fetch)
		else $error("no fetch after stacking");
	chk_push_hold: assert property (
		ctx_push_req && !ctx_push_done |=> ctx_push_req)
		else $error("stack request dropped early");
	chk_fetch_pulse: assert property (fetch_req |=> !fetch_req)
		else $error("fetch request too long");
	chk_vec_range: assert property (
		fetch_req |-> fetch_addr >= 16'hffe0 && !fetch_addr[0])
		else $error("vector outside table");
	chk_nmi_level: assert property (
		fetch_req && fetch_addr >= 16'hfffa |-> lvl == 2'h3)
		else $error("non-maskable entry level wrong");
	// reset entry skips stacking and fetches the reset vector
	chk_reset_entry: assert property (
		$rose(reset_n) |-> !ctx_push_req [*2]
		##1 (fetch_req && fetch_addr == 16'hfffe))
		else $error("reset entry wrong");
	chk_enable_lvl: assert property (
		enable_irqs_instr || halt_instr || wait_instr
		|=> fetch_req || lvl == 2'h2)
		else $error("level not lowered");
	chk_disable_lvl: assert property (
		disable_irqs_instr |=> fetch_req || lvl == 2'h3)
		else $error("level not raised");
	chk_return_lvl: assert property (
		return_from_handler |=> fetch_req || lvl == $past(popped_level))
		else $error("level not restored");
	chk_wake_up: assert property (
		$rose(ctx_push_req) |-> sleep_mode == SLP_AWAKE)
		else $error("still asleep at entry");
endmodule

bind npic_ctrl npic_ctrl_chk i_chk (.sys_clk, .reset_n, .ctx_push_req,
	.ctx_push_done, .fetch_req, .fetch_addr, .level_high_bit,
	.level_low_bit, .enable_irqs_instr, .disable_irqs_instr, .halt_instr,
	.wait_instr, .return_from_handler, .popped_level, .sleep_mode);

// ===== dv/npic_core_model.sv
// core-side partner: acknowledges stacking, keeps the saved level codes
`timescale 1ns/1ps
module npic_core_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic ctx_push_req,
	input wire logic [1:0] cur_level,
	input wire logic pop,
	input wire logic [3:0] delay,
	output logic ctx_push_done,
	output logic [1:0] popped_level
);
	logic [1:0] stk [8];
	logic [2:0] sp;
	logic [3:0] cnt;
	// no underflow guard: a return without an entry is a bench fault
	assign popped_level = stk[sp - 3'h1];
	// slow or prompt ack; the level is saved with the context
	always @(posedge sys_clk) begin
		ctx_push_done <= reset_n && ctx_push_req && !ctx_push_done &&
			cnt == delay;
		if (!reset_n) begin
			cnt <= 4'h0;
			sp <= 3'h0;
		end else if (ctx_push_req && !ctx_push_done) begin
			if (cnt == 4'h0) begin
				stk[sp] <= cur_level;
				sp <= sp + 3'h1;
			end
			cnt <= cnt + 4'h1;
		end else begin
			cnt <= 4'h0;
			if (pop) sp <= sp - 3'h1;
		end
	end
endmodule

// ===== dv/npic_ctrl_test.sv
// self-checking bench for the nested priority interrupt controller
`timescale 1ns/1ps
module npic_ctrl_test;
	import npic_pkg::*;
	logic sys_clk, reset_n, reg_wr, reg_rd, instr_done, ctx_push_done;
	logic ctx_push_req, fetch_req, level_high_bit, level_low_bit;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, ev;
	logic [13:0] periph_flag, periph_en, periph_clr;
	logic [15:0] ext_pin_sel, fetch_addr, lvl16;
	logic [1:0] popped_level;
	logic [3:0] delay;
	npic_sleep_t sleep_mode;
	int fails, compares;
	assign lvl16 = {14'h0, level_high_bit, level_low_bit};
	// ev: trap, return, enable, disable, halt, wait, top pin, ext pin
	npic_ctrl i_dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .top_level_pin_irq(ev[6]),
		.ext_pin_in({14'h0, ev[7], 1'b0}), .ext_pin_sel, .periph_flag,
		.periph_en, .periph_clr, .instr_done, .trap_instr(ev[0]),
		.return_from_handler(ev[1]), .popped_level,
		.enable_irqs_instr(ev[2]), .disable_irqs_instr(ev[3]),
		.halt_instr(ev[4]), .wait_instr(ev[5]), .ctx_push_done,
		.ctx_push_req, .fetch_req, .fetch_addr, .level_high_bit,
		.level_low_bit, .sleep_mode);
	npic_core_model i_core (.sys_clk, .reset_n, .ctx_push_req,
		.cur_level({level_high_bit, level_low_bit}), .pop(ev[1]), .delay,
		.ctx_push_done, .popped_level);
	// ---------------------------------------------
	// clock and helpers
	// ---------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task end_sim();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		chk({8'h0, reg_rdata}, {8'h0, e});
	endtask
	task pulse(input logic [7:0] m);
		@(posedge sys_clk);
		ev <= m;
		@(posedge sys_clk);
		ev <= 8'h00;
	endtask
	task lv(input logic [1:0] e);
		@(posedge sys_clk);
		chk(lvl16, {14'h0, e});
	endtask
	task idle(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			chk({15'h0, fetch_req}, 16'h0);
		end
	endtask
	// bounded wait for the vector fetch, then check address and level
	task serve(input logic [15:0] a, input logic [1:0] l);
		int n;
		n = 0;
		@(posedge sys_clk);
		while (fetch_req !== 1'b1 && n < 60) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 60) begin
			fails++;
			end_sim();
		end else begin
			chk(fetch_addr, a);
			chk(lvl16, {14'h0, l});
		end
	endtask
	// flag clear sequence of a peripheral
	task pclr(input int k);
		@(posedge sys_clk);
		periph_flag[k] <= 1'b0;
		periph_clr[k] <= 1'b1;
		@(posedge sys_clk);
		periph_clr <= 14'h0;
	endtask
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		reset_n = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ev = 8'h00;
		ext_pin_sel = 16'h0003;
		periph_flag = 14'h0;
		periph_en = 14'h3bff;
		periph_clr = 14'h0;
		instr_done = 1'b1;
		delay = 4'h0;
		fails = 0;
		compares = 0;
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		serve(16'hfffe, 2'h3);
		for (int i = 0; i < 4; i++) rd(3'(i), 8'hff);
		rd(3'h5, 8'h03);
		wr(3'h0, 8'hcf);
		wr(3'h0, 8'h64);
		rd(3'h0, 8'h44);
		wr(3'h3, 8'h00);
		rd(3'h3, 8'hf0);
		pulse(8'h04);
		lv(2'h2);
		pulse(8'h08);
		lv(2'h3);
		// masked edge request stays latched, then a higher one nests inside its handler
		pulse(8'h80);
		idle(6);
		rd(3'h6, 8'h04);
		pulse(8'h04);
		serve(16'hfff6, 2'h0);
		rd(3'h6, 8'h00);
		periph_flag[8] <= 1'b1;
		serve(16'hffea, 2'h3);
		pclr(8);
		pulse(8'h02);
		lv(2'h0);
		pulse(8'h02);
		lv(2'h2);
		// three at once, slow stacking: software level, then hardware order
		delay <= 4'h3;
		pulse(8'h08);
		wr(3'h1, 8'hdf);
		periph_flag <= 14'h05c0;
		rd(3'h7, 8'h01);
		rd(3'h6, 8'hc0);
		pulse(8'h04);
		serve(16'hffec, 2'h3);
		pclr(7);
		pulse(8'h02);
		serve(16'hffea, 2'h3);
		pclr(8);
		pulse(8'h02);
		serve(16'hffee, 2'h1);
		pclr(6);
		pulse(8'h02);
		periph_flag[10] <= 1'b0;
		pulse(8'h08);
		periph_flag[9] <= 1'b1;
		pclr(9);
		pulse(8'h04);
		idle(6);
		rd(3'h7, 8'h00);
		// trap waits for the instruction end; top pin preempts it
		instr_done <= 1'b0;
		pulse(8'h01);
		idle(5);
		instr_done <= 1'b1;
		serve(16'hfffc, 2'h3);
		pulse(8'h40);
		serve(16'hfffa, 2'h3);
		pulse(8'h02);
		pulse(8'h02);
		lv(2'h2);
		// halt: only a halt-capable source wakes, the other follows
		pulse(8'h08);
		periph_flag[8] <= 1'b1;
		pulse(8'h10);
		idle(5);
		chk({14'h0, sleep_mode}, {14'h0, SLP_HALT});
		pulse(8'h80);
		serve(16'hfff6, 2'h0);
		serve(16'hffea, 2'h3);
		pclr(8);
		pulse(8'h02);
		pulse(8'h02);
		// wait: any source wakes
		pulse(8'h20);
		@(posedge sys_clk);
		chk({14'h0, sleep_mode}, {14'h0, SLP_WAIT});
		periph_flag[8] <= 1'b1;
		serve(16'hffea, 2'h3);
		chk({14'h0, sleep_mode}, {14'h0, SLP_AWAKE});
		pclr(8);
		pulse(8'h02);
		// top pin on the falling edge, then held off by its enable
		wr(3'h5, 8'h01);
		pulse(8'h40);
		serve(16'hfffa, 2'h3);
		rd(3'h4, 8'h0b);
		pulse(8'h02);
		rd(3'h4, 8'h02);
		wr(3'h5, 8'h00);
		pulse(8'h40);
		idle(12);
		rd(3'h6, 8'h01);
		end_sim();
	end
endmodule
